// >>> fap_power_ctrl.sv
/*
 * Floppy controller power manager with its APB register window.
 * Assumes the controller core shares pclk and reports idle state here.
 */
// Added by the designer: the APB interface to the registers.
`include "fap_consts.svh"
`default_nettype none
module fap_power_ctrl #(
  parameter int unsigned IDLE_CYCLES = `FAP_IDLE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller core status
  input wire logic [7:0] core_main_status,
  input wire logic core_int,
  input wire logic core_head_unloaded,
  input wire logic [7:0] core_rd_data,
  input wire logic [7:0] core_status_a,
  input wire logic [7:0] core_status_b,
  input wire logic [7:0] core_drive_in,
  input wire logic core_wr_data,
  input wire logic core_wr_gate,
  // Controller core control
  output logic core_data_wr,
  output logic core_data_rd,
  output logic [7:0] core_wr_byte,
  output logic core_soft_reset,
  output logic [7:0] core_rate_sel,
  output logic [7:0] core_ccr,
  output logic core_powered_down,
  // Chip pin
  input wire logic power_good_input,
  // Drive pins
  output logic [3:0] drive_motor,
  output logic [3:0] drive_select,
  output logic drive_wr_data,
  output logic drive_wr_gate,
  output logic drive_oen
);
  fap_pkg::fap_auto_st_t st_q;
  logic [7:0] cfg0_q, cfg7_q, dor_q, dsr_q, ccr_q;
  logic dsr_pd_q, auto_en_q, pgood;
  logic setup, access, rd_acc, wr_acc, hit, lapsed;
  logic msr_rd, data_acc, motor_wr, dor_rst, dsr_rst, soft_rst;
  logic wake, enter, auto_en, direct_pd, pd;
  logic [5:0] idx;
  logic [7:0] rd_mux;

  function automatic logic at(input logic [7:0] a, input logic [5:0] i);
    at = (a[1:0] == 2'b00) && (a[7:2] == i);
  endfunction

  fap_sync u_pgood (
    .pclk(pclk),
    .presetn(presetn),
    .pin(power_good_input),
    .level(pgood)
  );

  assign idx = paddr[7:2];
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign rd_acc = access && !pwrite;
  assign wr_acc = access && pwrite;
  // One wait-free access phase; prdata is captured at the setup edge.
  assign pready = penable;
  assign hit = at(paddr, `FAP_IDX_STATUS_A) || at(paddr, `FAP_IDX_STATUS_B)
    || at(paddr, `FAP_IDX_DIG_OUT) || at(paddr, `FAP_IDX_RATE_MAIN)
    || at(paddr, `FAP_IDX_DATA) || at(paddr, `FAP_IDX_DIR_CCR)
    || at(paddr, `FAP_IDX_CFG_ZERO) || at(paddr, `FAP_IDX_CFG_SEVEN)
    || at(paddr, `FAP_IDX_PWR_STAT);
  assign pslverr = access && !hit;

  // Wake sources; reads of the digital output never count.
  assign msr_rd = rd_acc && at(paddr, `FAP_IDX_RATE_MAIN); // R14
  assign data_acc = access && at(paddr, `FAP_IDX_DATA); // R14
  assign motor_wr = wr_acc && at(paddr, `FAP_IDX_DIG_OUT)
    && (pwdata[`FAP_DOR_MOTOR_LO +: 4] != 4'h0); // R10
  assign dor_rst = wr_acc && at(paddr, `FAP_IDX_DIG_OUT)
    && !pwdata[`FAP_DOR_RESET_N]; // R15
  assign dsr_rst = wr_acc && at(paddr, `FAP_IDX_RATE_MAIN)
    && pwdata[`FAP_DSR_SOFT_RST]; // R15
  assign soft_rst = dor_rst || dsr_rst;
  assign wake = msr_rd || data_acc || motor_wr || soft_rst; // R10

  assign auto_en = cfg7_q[`FAP_CFG7_FDC_AUTO]; // R2
  assign direct_pd = !cfg0_q[`FAP_CFG0_FDC_PWR]; // R1
  // A wake in the entry cycle wins, so an access is never lost to sleep.
  assign enter = auto_en && !dsr_pd_q && !wake
    && (dor_q[`FAP_DOR_MOTOR_LO +: 4] == 4'h0)
    && (core_main_status == `FAP_MSR_IDLE) && !core_int
    && core_head_unloaded && lapsed; // R4 R5 R8
  assign pd = direct_pd || dsr_pd_q || !pgood
    || (st_q == fap_pkg::FAP_ASLEEP); // R1 R17

  // Every wake reloads the count, so a woken controller gets the full
  // idle time again before it may sleep.
  fap_idle_timer #(
    .CYCLES(IDLE_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .enable(auto_en), // R5
    .restart((auto_en && !auto_en_q) || msr_rd || data_acc || wake), // R3 R11
    .lapsed(lapsed)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_en_q <= 1'b0;
    end else begin
      auto_en_q <= auto_en;
    end
  end

  // Auto powerdown state; the rate-select powerdown holds it off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= fap_pkg::FAP_AWAKE;
    end else begin
      case (st_q)
        fap_pkg::FAP_AWAKE: begin
          if (enter) begin
            st_q <= fap_pkg::FAP_ASLEEP; // R4
          end
        end
        fap_pkg::FAP_ASLEEP: begin
          if (wake || !auto_en) begin
            st_q <= fap_pkg::FAP_AWAKE; // R9 R10 R5
          end
        end
        default: begin
          st_q <= fap_pkg::FAP_AWAKE;
        end
      endcase
    end
  end

  // Configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0_q <= `FAP_CFG0_RESET;
      cfg7_q <= `FAP_CFG7_RESET;
    end else if (wr_acc && at(paddr, `FAP_IDX_CFG_ZERO)) begin
      cfg0_q <= pwdata[7:0];
    end else if (wr_acc && at(paddr, `FAP_IDX_CFG_SEVEN)) begin
      cfg7_q <= pwdata[7:0];
    end
  end

  // Controller registers keep their values in any power state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dor_q <= `FAP_DOR_RESET;
      ccr_q <= `FAP_CCR_RESET;
    end else if (wr_acc && at(paddr, `FAP_IDX_DIG_OUT)) begin
      dor_q <= pwdata[7:0]; // R12 R13
    end else if (wr_acc && at(paddr, `FAP_IDX_DIR_CCR)) begin
      ccr_q <= pwdata[7:0]; // R13
    end
  end

  // The reset bit of the rate select is self-clearing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsr_q <= 8'h00;
    end else if (wr_acc && at(paddr, `FAP_IDX_RATE_MAIN)) begin
      dsr_q <= {1'b0, pwdata[6:0]}; // R13
    end
  end

  // Rate-select powerdown ends on a waking access or software reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsr_pd_q <= 1'b0;
    end else if (wr_acc && at(paddr, `FAP_IDX_RATE_MAIN)
        && pwdata[`FAP_DSR_PWR_DOWN] && !pwdata[`FAP_DSR_SOFT_RST]) begin
      dsr_pd_q <= 1'b1; // R8
    end else if (wake) begin
      dsr_pd_q <= 1'b0; // R8
    end
  end

  // Core strobes and software reset run a normal reset sequence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_data_wr <= 1'b0;
      core_data_rd <= 1'b0;
      core_wr_byte <= 8'h00;
      core_soft_reset <= 1'b0;
    end else begin
      core_data_wr <= data_acc && pwrite;
      core_data_rd <= data_acc && !pwrite;
      core_soft_reset <= soft_rst; // R9
      if (data_acc && pwrite) begin
        core_wr_byte <= pwdata[7:0];
      end
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      `FAP_IDX_STATUS_A: rd_mux = core_status_a;
      `FAP_IDX_STATUS_B: rd_mux = core_status_b;
      `FAP_IDX_DIG_OUT: rd_mux = dor_q;
      `FAP_IDX_RATE_MAIN: rd_mux = core_main_status;
      `FAP_IDX_DATA: rd_mux = core_rd_data;
      `FAP_IDX_DIR_CCR: rd_mux = core_drive_in;
      `FAP_IDX_CFG_ZERO: rd_mux = cfg0_q;
      `FAP_IDX_CFG_SEVEN: rd_mux = cfg7_q;
      `FAP_IDX_PWR_STAT:
        rd_mux = {3'h0, lapsed, !pgood, dsr_pd_q, st_q, pd};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is sampled in the setup cycle, so reads never stall.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= {24'h000000, hit && paddr[1:0] == 2'b00 ? rd_mux : 8'h00};
    end
  end

  // Drive-side pins released while down; host interface stays live.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_motor <= 4'h0;
      drive_select <= 4'h0;
      drive_wr_data <= 1'b0;
      drive_wr_gate <= 1'b0;
      drive_oen <= 1'b1;
      core_powered_down <= 1'b0;
      core_rate_sel <= 8'h00;
      core_ccr <= `FAP_CCR_RESET;
    end else begin
      drive_oen <= pd; // R16
      drive_motor <= pd ? 4'h0 : dor_q[`FAP_DOR_MOTOR_LO +: 4]; // R16
      drive_select <= pd ? 4'h0 : 4'(4'h1 << dor_q[1:0]); // R16
      drive_wr_data <= !pd && core_wr_data; // R16
      drive_wr_gate <= !pd && core_wr_gate; // R16
      core_powered_down <= pd;
      core_rate_sel <= dsr_q;
      core_ccr <= ccr_q;
    end
  end

  // Checks sample on pclk and stay quiet while reset is held.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_asleep_wake;
    st_q == fap_pkg::FAP_ASLEEP && wake;
  endsequence

  sequence s_dor_read_only;
    rd_acc && at(paddr, `FAP_IDX_DIG_OUT) && !wake;
  endsequence

  sequence s_rate_pd_write;
    wr_acc && at(paddr, `FAP_IDX_RATE_MAIN) && pwdata[`FAP_DSR_PWR_DOWN]
      && !pwdata[`FAP_DSR_SOFT_RST];
  endsequence

  a_direct_pd_pins: assert property ( // R1
    direct_pd |=> drive_oen && drive_motor == 4'h0)
    else $error("direct powerdown left drive pins on");
  a_auto_disabled: assert property ( // R5
    !auto_en |=> st_q == fap_pkg::FAP_AWAKE && !lapsed)
    else $error("auto powerdown active while disabled");
  a_entry_cause: assert property ( // R4
    $rose(st_q == fap_pkg::FAP_ASLEEP) |-> $past(lapsed) && $past(!core_int)
      && $past(core_main_status) == `FAP_MSR_IDLE)
    else $error("powerdown entered without idle conditions");
  a_wake_access: assert property ( // R10
    s_asleep_wake |=> st_q == fap_pkg::FAP_AWAKE ##1 !drive_oen || pd)
    else $error("waking access did not wake");
  a_dor_read_stay: assert property ( // R14
    st_q == fap_pkg::FAP_ASLEEP && auto_en ##0 s_dor_read_only
      |=> st_q == fap_pkg::FAP_ASLEEP)
    else $error("digital output read woke the controller");
  a_timer_restart: assert property ( // R3
    auto_en && data_acc |=> !lapsed [*3])
    else $error("data access did not restart idle timer");
  // A wake in the same cycle ends the rate-select powerdown at once.
  a_dsr_override: assert property ( // R8
    dsr_pd_q && !wake |-> !enter ##1 pd ##1 drive_oen)
    else $error("rate select powerdown not in force");
  a_nonwake_store: assert property ( // R13
    st_q == fap_pkg::FAP_ASLEEP && wr_acc && at(paddr, `FAP_IDX_DIR_CCR)
      |=> ccr_q == $past(pwdata[7:0]) && st_q == fap_pkg::FAP_ASLEEP)
    else $error("non-waking write lost or woke controller");
  a_soft_reset: assert property ( // R15
    soft_rst |=> core_soft_reset && st_q == fap_pkg::FAP_AWAKE)
    else $error("software reset did not wake and reset");
  a_power_good: assert property ( // R17
    !pgood |=> drive_oen && core_powered_down)
    else $error("power good low did not power down");

  // The core only sees registered strobes, so each one is checked here.
  a_drive_gated: assert property ( // R16
    pd |=> !drive_wr_data && !drive_wr_gate && drive_select == 4'h0)
    else $error("drive write pins active while powered down");
  a_rate_pd_set: assert property ( // R8
    s_rate_pd_write |=> dsr_pd_q && pd)
    else $error("rate select powerdown not entered");
  a_wake_restart: assert property ( // R11
    s_asleep_wake |=> !lapsed [*3])
    else $error("wake did not restart idle timer");
  a_enter_blocked: assert property ( // R4
    st_q == fap_pkg::FAP_AWAKE && (core_int || !core_head_unloaded
      || dor_q[`FAP_DOR_MOTOR_LO +: 4] != 4'h0)
      |=> st_q == fap_pkg::FAP_AWAKE)
    else $error("powerdown entered while controller busy");
  a_data_strobe: assert property ( // R10
    data_acc |=> core_data_wr == $past(pwrite)
      && core_data_rd == !$past(pwrite))
    else $error("data access strobe missing");
  a_core_pd_level: assert property ( // R16
    $rose(pd) |=> core_powered_down && drive_oen)
    else $error("core not told of powerdown");
  a_dor_write_keep: assert property ( // R13
    st_q == fap_pkg::FAP_ASLEEP && wr_acc && !wake
      && at(paddr, `FAP_IDX_DIG_OUT)
      |=> dor_q == $past(pwdata[7:0]) && st_q == fap_pkg::FAP_ASLEEP)
    else $error("non-waking output write lost or woke controller");
  a_soft_pulse: assert property ( // R15
    soft_rst |=> core_soft_reset ##1 !core_soft_reset)
    else $error("software reset pulse not one cycle");
  a_enable_start: assert property ( // R3
    $rose(auto_en) |=> !lapsed [*2])
    else $error("idle timer not started on enable");
endmodule
`default_nettype wire

// >>> fap_consts.svh
/*
 * Offsets, field positions, reset values and timing counts of the floppy
 * controller power manager. Assumes a 20 MHz register clock.
 */
// How it works
// R1: Config zero bit 3 forces direct powerdown.
// R2: Config seven bit 7 enables auto powerdown.
// R3: Enable starts timer; status/data access restarts.
// R4: Enter only when motors off, idle, timers expired.
// R5: Disabling cancels timer and blocks auto entry.
// R6: Host waits 8 us after auto wake.
// R7: Host waits 8/4 us after direct powerdown.
// R8: Rate select powerdown overrides auto powerdown.
// R9: Reset wake resets; access wake keeps state.
// R10: Motor write, status read, data access wake.
// R11: After wake, idle timer restarts for 10 ms.
// R12: All registers stay reachable in every state.
// R13: Non-waking accesses keep powerdown and store data.
// R14: Of reads, only status read and data access wake.
// R15: Software reset bits wake; other bits do not.
// R16: Drive pins disabled while powered down.
// R17: Power-good pin gives chip-level powerdown.
`ifndef FAP_CONSTS_SVH
`define FAP_CONSTS_SVH

`define FAP_IDX_STATUS_A 6'h00
`define FAP_IDX_STATUS_B 6'h01
`define FAP_IDX_DIG_OUT 6'h02
`define FAP_IDX_RATE_MAIN 6'h04
`define FAP_IDX_DATA 6'h05
`define FAP_IDX_DIR_CCR 6'h07
`define FAP_IDX_CFG_ZERO 6'h10
`define FAP_IDX_CFG_SEVEN 6'h11
`define FAP_IDX_PWR_STAT 6'h12

`define FAP_CFG0_FDC_PWR 3
`define FAP_CFG7_FDC_AUTO 7
`define FAP_DOR_RESET_N 2
`define FAP_DOR_MOTOR_LO 4
`define FAP_DSR_SOFT_RST 7
`define FAP_DSR_PWR_DOWN 6

`define FAP_CFG0_RESET 8'h08
`define FAP_CFG7_RESET 8'h00
`define FAP_DOR_RESET 8'h04
`define FAP_CCR_RESET 8'h00
`define FAP_MSR_IDLE 8'h80

`define FAP_IDLE_TIME_MS 10
`define FAP_CLK_HZ 20000000
`define FAP_IDLE_CYCLES ((`FAP_IDLE_TIME_MS * `FAP_CLK_HZ) / 1000)

`endif

// >>> fap_pkg.sv
/*
 * Types of the floppy controller power manager.
 * Assumes fap_consts.svh is compiled alongside.
 */
`default_nettype none
package fap_pkg;
  typedef enum logic [0:0] {
    FAP_AWAKE = 1'b0,
    FAP_ASLEEP = 1'b1
  } fap_auto_st_t;
endpackage
`default_nettype wire

// >>> fap_sync.sv
/*
 * Two flip-flop synchroniser for one asynchronous pin.
 * Assumes the pin may change at any time relative to pclk.
 */
`default_nettype none
module fap_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level in and out
  input wire logic pin,
  output logic level
);
  logic meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      level <= 1'b0;
    end else begin
      meta_q <= pin;
      level <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> fap_idle_timer.sv
/*
 * Down counter for the auto powerdown idle time.
 * Assumes restart and enable come from logic on pclk.
 */
`default_nettype none
module fap_idle_timer #(
  parameter int unsigned CYCLES = 200000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic enable,
  input wire logic restart,
  // Status
  output logic lapsed
);
  logic [17:0] count_q;

  // A restart wins over the countdown so no access is missed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 18'h00000;
      lapsed <= 1'b0;
    end else if (!enable) begin
      count_q <= 18'h00000;
      lapsed <= 1'b0;
    end else if (restart) begin
      count_q <= 18'(CYCLES - 1);
      lapsed <= 1'b0;
    end else if (count_q != 18'h00000) begin
      count_q <= count_q - 18'h00001;
    end else begin
      lapsed <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> fap_host_model.sv
/*
 * APB host model that issues register accesses to the power manager.
 * Assumes one clock, pclk, shared with the slave.
 */
`default_nettype none
module fap_host_model (
  // Clock
  input wire logic pclk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hFF;
    pwdata = 32'h0;
  end

  // Released address and data are inverted so stale values never match.
  task automatic xfer(input logic wr, input logic [5:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~{idx, 2'b00};
    pwdata <= ~wd;
  endtask

  // The controller needs 8 us after a wake before commands: 160 cycles.
  task automatic settle();
    repeat (160) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// >>> fap_power_ctrl_tb.sv
/*
 * Self-checking bench of the floppy controller power manager.
 * Assumes fap_consts.svh and the host model are compiled alongside.
 */
`include "fap_consts.svh"
`default_nettype none
module fap_power_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [7:0] main_status, rdd, sta, stb, din, wbyte, rsel, config_control;
  logic cint, chu, cwd, cwg, cdw, cdr, csr, cpd, pgood;
  logic [3:0] dmot, dsel;
  logic dwd, dwg, doen;
  int fail_count;
  int checks_done;

  fap_host_model fap_host_model_inst (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  fap_power_ctrl #(.IDLE_CYCLES(IDLE)) fap_power_ctrl_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_main_status(main_status), .core_int(cint),
    .core_head_unloaded(chu), .core_rd_data(rdd), .core_status_a(sta),
    .core_status_b(stb), .core_drive_in(din), .core_wr_data(cwd),
    .core_wr_gate(cwg), .core_data_wr(cdw), .core_data_rd(cdr),
    .core_wr_byte(wbyte), .core_soft_reset(csr), .core_rate_sel(rsel),
    .core_ccr(config_control), .core_powered_down(cpd), .power_good_input(pgood),
    .drive_motor(dmot), .drive_select(dsel), .drive_wr_data(dwd),
    .drive_wr_gate(dwg), .drive_oen(doen));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input string n, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] v);
    fap_host_model_inst.xfer(1'b1, i, {24'h0, v}, d, e);
  endtask

  task automatic rd(input logic [5:0] i);
    fap_host_model_inst.xfer(1'b0, i, 32'h0, d, e);
  endtask

  // Power status low nibble: pd, asleep, rate-select pd, power good low.
  task automatic ps(input logic [31:0] x);
    rd(`FAP_IDX_PWR_STAT);
    chk("pwr_stat", d & 32'h0F, x);
  endtask

  task automatic stop_test();
    $display("checks_done %0d fail_count %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic t_reset();
    rd(`FAP_IDX_CFG_ZERO);
    chk("cfg0", d, 32'h08);
    chk("cfg0_err", {31'h0, e}, 32'h0);
    rd(`FAP_IDX_CFG_SEVEN);
    chk("cfg7", d, 32'h00);
    rd(`FAP_IDX_DIG_OUT);
    chk("dor", d, 32'h04);
    ps(32'h00);
    rd(6'h3F);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    chk("unmapped_rd", d, 32'h0);
  endtask

  task automatic t_direct();
    wr(`FAP_IDX_DIG_OUT, 8'h15);
    wt(2);
    chk("motor_on", {28'h0, dmot}, 32'h1);
    chk("wr_pins_on", {30'h0, dwd, dwg}, 32'h3);
    wr(`FAP_IDX_CFG_ZERO, 8'h00);
    wt(2);
    ps(32'h01);
    chk("oen_direct", {31'h0, doen}, 32'h1);
    chk("motor_down", {28'h0, dmot}, 32'h0);
    chk("wr_pins_down", {30'h0, dwd, dwg}, 32'h0);
    wr(`FAP_IDX_CFG_ZERO, 8'h08);
    wt(2);
    ps(32'h00);
    fap_host_model_inst.settle();
    wr(`FAP_IDX_DIG_OUT, 8'h04);
  endtask

  task automatic t_auto();
    wr(`FAP_IDX_CFG_SEVEN, 8'h80);
    wt(IDLE / 2);
    ps(32'h00);
    wt(IDLE);
    ps(32'h03);
    chk("oen_auto", {31'h0, doen}, 32'h1);
    chk("core_pd", {31'h0, cpd}, 32'h1);
    @(posedge pclk);
    sta <= 8'hA5;
    rd(`FAP_IDX_STATUS_A);
    chk("status_a", d, 32'hA5);
    wr(`FAP_IDX_DIR_CCR, 8'h02);
    wr(`FAP_IDX_DIG_OUT, 8'h05);
    wr(`FAP_IDX_RATE_MAIN, 8'h02);
    rd(`FAP_IDX_DIG_OUT);
    chk("dor_asleep", d, 32'h05);
    ps(32'h03);
    chk("sel_asleep", {28'h0, dsel}, 32'h0);
    chk("rate_sel", {24'h0, rsel}, 32'h02);
    rd(`FAP_IDX_RATE_MAIN);
    chk("msr", d, 32'h80);
    ps(32'h00);
    chk("ccr_kept", {24'h0, config_control}, 32'h02);
    chk("sel_kept", {28'h0, dsel}, 32'h2);
    wt(IDLE / 2);
    ps(32'h00);
    wt(IDLE);
    ps(32'h03);
  endtask

  task automatic t_wakes();
    logic ww [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [5:0] ix [5] = '{`FAP_IDX_DATA, `FAP_IDX_DATA, `FAP_IDX_DIG_OUT,
                           `FAP_IDX_DIG_OUT, `FAP_IDX_RATE_MAIN};
    logic [7:0] vv [5] = '{8'h00, 8'h3C, 8'h14, 8'h00, 8'h80};
    logic [2:0] pp [5] = '{3'h4, 3'h2, 3'h0, 3'h1, 3'h1};
    for (int i = 0; i < 5; i++) begin
      fap_host_model_inst.xfer(ww[i], ix[i], {24'h0, vv[i]}, d, e);
      @(negedge pclk);
      chk("core_pulse", {29'h0, cdr, cdw, csr}, {29'h0, pp[i]});
      @(negedge pclk);
      chk("pulse_end", {29'h0, cdr, cdw, csr}, 32'h0);
      if (i == 0) chk("data_rd", d, 32'hC3);
      ps(32'h00);
      wr(`FAP_IDX_DIG_OUT, 8'h04);
      wt(IDLE + 10);
      ps(32'h03);
    end
    chk("wr_byte", {24'h0, wbyte}, 32'h3C);
    chk("rate_sel_clr", {24'h0, rsel}, 32'h00);
  endtask

  task automatic t_block();
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      cint <= (k == 0);
      main_status <= (k == 1) ? 8'h81 : 8'h80;
      chu <= (k != 2);
      if (k == 3) wr(`FAP_IDX_DIG_OUT, 8'h14);
      else rd(`FAP_IDX_RATE_MAIN);
      wt(IDLE + 10);
      ps(32'h00);
      @(posedge pclk);
      cint <= 1'b0;
      main_status <= 8'h80;
      chu <= 1'b1;
      wr(`FAP_IDX_DIG_OUT, 8'h04);
      wt(IDLE + 10);
      ps(32'h03);
    end
  endtask

  task automatic t_disable();
    wr(`FAP_IDX_CFG_SEVEN, 8'h00);
    ps(32'h00);
    wt(IDLE + 10);
    rd(`FAP_IDX_PWR_STAT);
    chk("timer_off", d & 32'h1F, 32'h00);
  endtask

  task automatic t_rate_pd();
    wr(`FAP_IDX_CFG_SEVEN, 8'h80);
    wr(`FAP_IDX_RATE_MAIN, 8'h40);
    ps(32'h05);
    chk("rate_sel_pd", {24'h0, rsel}, 32'h40);
    wt(IDLE + 10);
    ps(32'h05);
    rd(`FAP_IDX_RATE_MAIN);
    ps(32'h00);
    wt(IDLE + 10);
    ps(32'h03);
  endtask

  task automatic t_pgood();
    @(posedge pclk);
    pgood <= 1'b0;
    wt(4);
    rd(`FAP_IDX_PWR_STAT);
    chk("pgood_low", d & 32'h09, 32'h09);
    chk("oen_pgood", {31'h0, doen}, 32'h1);
    @(posedge pclk);
    pgood <= 1'b1;
    wt(4);
  endtask

  task automatic t_hw_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    wt(4);
    ps(32'h00);
    rd(`FAP_IDX_CFG_SEVEN);
    chk("cfg7_reset", d, 32'h00);
    chk("ccr_reset", {24'h0, config_control}, 32'h00);
  endtask

  initial begin
    fail_count = 0;
    checks_done = 0;
    presetn = 1'b0;
    main_status = 8'h80;
    cint = 1'b0;
    chu = 1'b1;
    rdd = 8'hC3;
    sta = 8'h11;
    stb = 8'h22;
    din = 8'h33;
    cwd = 1'b1;
    cwg = 1'b1;
    pgood = 1'b1;
    wt(2);
    presetn <= 1'b1;
    wt(4);
    t_reset();
    t_direct();
    t_auto();
    t_wakes();
    t_block();
    t_disable();
    t_rate_pd();
    t_pgood();
    t_hw_reset();
    stop_test();
  end

  // A hang is cut short well past the expected thousand or so cycles.
  initial begin
    wt(20000);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
